// [shared/nvmem_pkg.sv]
package nvmem_pkg;
    localparam int BYTE_W = 8;
    localparam int ADDR_W = 15;
    localparam int DEPTH = 32768;
    localparam int STRAP_W = 3;
    localparam int TYPE_W = 4;
    localparam int SYNC_W = 6;
    // synchroniser lanes
    localparam int LANE_SCL = 0;
    localparam int LANE_SDA = 1;
    localparam int LANE_STRAP = 2;
    localparam int LANE_WP = 5;
    // address byte fields
    localparam int TYPE_LSB = 4;
    localparam int STRAP_LSB = 1;
    localparam int DIR_BIT = 0;
    localparam logic DIR_READ = 1'b1;
    // value is arbitrary, not tied to any part
    localparam logic [TYPE_W-1:0] TYPE_CODE_DEF = 4'h5;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [3:0] BIT_LAST = 4'h7;
    localparam logic [3:0] CNT_ZERO = 4'h0;
    localparam logic [3:0] CNT_STEP = 4'h1;
    localparam logic [ADDR_W-1:0] ADDR_STEP = 15'h0001;
    localparam logic [ADDR_W-1:0] ADDR_RST = 15'h0000;
    localparam logic [BYTE_W-1:0] BYTE_ZERO = 8'h00;
    // index of the byte inside a frame, saturates at data
    localparam logic [1:0] IDX_DEV = 2'h0;
    localparam logic [1:0] IDX_HI = 2'h1;
    localparam logic [1:0] IDX_LO = 2'h2;
    localparam logic [1:0] IDX_DATA = 2'h3;
    localparam logic [1:0] IDX_STEP = 2'h1;
    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_RX = 5'h02,
        ST_ACK = 5'h04,
        ST_TX = 5'h08,
        ST_MACK = 5'h10
    } bus_state_t;
endpackage

// [shared/mem_port_if.sv]
`timescale 1ns/10ps
interface mem_port_if;
    logic we;
    logic [nvmem_pkg::ADDR_W-1:0] addr;
    logic [nvmem_pkg::BYTE_W-1:0] wdata;
    logic [nvmem_pkg::BYTE_W-1:0] rdata;
    modport ctrl (output we, output addr, output wdata, input rdata);
    modport array (input we, input addr, input wdata, output rdata);
endinterface

// [hw/nvmem_array.sv]
`timescale 1ns/10ps
module nvmem_array #(
    parameter int DEPTH = nvmem_pkg::DEPTH,
    parameter int ADDR_W = nvmem_pkg::ADDR_W
) (
    // clock
    input wire logic clk_in,
    input wire logic rst_in,
    // access port
    mem_port_if.array bus
);
    generate
        if (DEPTH != (1 << ADDR_W)) begin : g_bad_depth
            $error("depth must fill the address space so the counter rolls over");
        end
    endgenerate

    // contents survive reset, only the read register is cleared
    logic [nvmem_pkg::BYTE_W-1:0] mem_q [DEPTH];
    logic [nvmem_pkg::BYTE_W-1:0] rdata_q;

    always_ff @(posedge clk_in) begin
        if (bus.we) begin
            mem_q[bus.addr] <= bus.wdata;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            rdata_q <= nvmem_pkg::BYTE_ZERO;
        end else begin
            rdata_q <= mem_q[bus.addr];
        end
    end

    assign bus.rdata = rdata_q;
endmodule

// [hw/nvmem_bus_slave.sv]
`timescale 1ns/10ps
// Summary of operation
// - 32768 byte array, readable and writable
// - respond only when address code matches straps
// - open strap pin reads as low; the module has no pull-down and relies on an external one
// - data line open drain, never driven high
// - sample on clock rise, change on fall
// - write protect high blocks all writes
// - reads work whatever write protect level
// - open write protect reads low, writes allowed; the module has no pull-down and relies on an external one
// - slave only, waits to be addressed
// - data changes only while clock low
// - stop ends operation, back to standby
// - writes commit at once, no wait
// - eight bit units, each with ack slot
// - receiver pulls low on ninth clock
// - transmitter releases line on ninth clock
// - stop before ack completes abandons operation
// - after not-acknowledge, release the bus
// - address byte: type, straps high first, direction
// - direction 0 writes, 1 reads
// - code mismatch: no ack, back to standby
// - two memory address bytes, each acknowledged
module nvmem_bus_slave #(
    parameter logic [nvmem_pkg::TYPE_W-1:0] TYPE_CODE = nvmem_pkg::TYPE_CODE_DEF
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // two-wire bus
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_out,
    // straps and protect
    input wire logic strap_addr_bit0,
    input wire logic strap_addr_bit1,
    input wire logic strap_addr_bit2,
    input wire logic wp_in
);
    // external pull-downs make open straps and protect read low
    logic [nvmem_pkg::SYNC_W-1:0] pins_c;
    logic [nvmem_pkg::SYNC_W-1:0] s1_q;
    logic [nvmem_pkg::SYNC_W-1:0] s2_q;
    logic [1:0] prev_q;
    logic scl_v;
    logic sda_v;
    logic wp_v;
    logic [nvmem_pkg::STRAP_W-1:0] strap_v;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;

    assign pins_c = {wp_in, strap_addr_bit2, strap_addr_bit1, strap_addr_bit0, sda_in, scl_in};

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            s1_q <= '1;
            s2_q <= '1;
            prev_q <= 2'h3;
        end else begin
            s1_q <= pins_c;
            s2_q <= s1_q;
            prev_q <= s2_q[nvmem_pkg::LANE_SDA:nvmem_pkg::LANE_SCL];
        end
    end

    assign scl_v = s2_q[nvmem_pkg::LANE_SCL];
    assign sda_v = s2_q[nvmem_pkg::LANE_SDA];
    assign wp_v = s2_q[nvmem_pkg::LANE_WP];
    assign strap_v = s2_q[nvmem_pkg::LANE_STRAP +: nvmem_pkg::STRAP_W];
    assign scl_rise = scl_v && !prev_q[nvmem_pkg::LANE_SCL];
    assign scl_fall = !scl_v && prev_q[nvmem_pkg::LANE_SCL];
    // both phases high keeps a data edge near a clock edge from faking a condition
    assign start_det = scl_v && prev_q[nvmem_pkg::LANE_SCL]
        && !sda_v && prev_q[nvmem_pkg::LANE_SDA];
    assign stop_det = scl_v && prev_q[nvmem_pkg::LANE_SCL]
        && sda_v && !prev_q[nvmem_pkg::LANE_SDA];

    mem_port_if mem_bus();

    nvmem_array #(
        .DEPTH(nvmem_pkg::DEPTH),
        .ADDR_W(nvmem_pkg::ADDR_W)
    ) u_array (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .bus(mem_bus.array)
    );

    nvmem_pkg::bus_state_t state_q;
    nvmem_pkg::bus_state_t state_d;
    logic [3:0] bit_cnt_q;
    logic [3:0] bit_cnt_d;
    logic [nvmem_pkg::BYTE_W-1:0] shift_q;
    logic [nvmem_pkg::BYTE_W-1:0] shift_d;
    logic [1:0] idx_q;
    logic [1:0] idx_d;
    logic rd_dir_q;
    logic rd_dir_d;
    logic ackd_q;
    logic ackd_d;
    logic [nvmem_pkg::ADDR_W-1:0] addr_q;
    logic [nvmem_pkg::ADDR_W-1:0] addr_d;
    logic oe_q;
    logic oe_d;
    logic we_c;
    logic match_c;
    logic [nvmem_pkg::BYTE_W-1:0] rdata;

    assign rdata = mem_bus.rdata;
    assign match_c = (shift_q[nvmem_pkg::TYPE_LSB +: nvmem_pkg::TYPE_W] == TYPE_CODE)
        && (shift_q[nvmem_pkg::STRAP_LSB +: nvmem_pkg::STRAP_W] == strap_v);

    always_comb begin
        state_d = state_q;
        bit_cnt_d = bit_cnt_q;
        shift_d = shift_q;
        idx_d = idx_q;
        rd_dir_d = rd_dir_q;
        ackd_d = ackd_q;
        addr_d = addr_q;
        oe_d = oe_q;
        we_c = 1'b0;
        if (stop_det) begin
            state_d = nvmem_pkg::ST_IDLE;
            oe_d = 1'b0;
        end else if (start_det) begin
            state_d = nvmem_pkg::ST_RX;
            bit_cnt_d = nvmem_pkg::CNT_ZERO;
            idx_d = nvmem_pkg::IDX_DEV;
            oe_d = 1'b0;
        end else begin
            unique case (state_q)
                nvmem_pkg::ST_IDLE: begin
                    oe_d = 1'b0;
                end
                nvmem_pkg::ST_RX: begin
                    if (scl_rise && bit_cnt_q != nvmem_pkg::BITS_PER_BYTE) begin
                        shift_d = {shift_q[nvmem_pkg::BYTE_W-2:0], sda_v};
                        bit_cnt_d = bit_cnt_q + nvmem_pkg::CNT_STEP;
                    end else if (scl_fall && bit_cnt_q == nvmem_pkg::BITS_PER_BYTE) begin
                        if (idx_q == nvmem_pkg::IDX_DEV) begin
                            if (match_c) begin
                                rd_dir_d = (shift_q[nvmem_pkg::DIR_BIT]
                                    == nvmem_pkg::DIR_READ);
                                oe_d = 1'b1;
                                state_d = nvmem_pkg::ST_ACK;
                            end else begin
                                state_d = nvmem_pkg::ST_IDLE;
                            end
                        end else begin
                            oe_d = 1'b1;
                            state_d = nvmem_pkg::ST_ACK;
                            if (idx_q == nvmem_pkg::IDX_HI) begin
                                // top bit of the high byte lies outside the array
                                addr_d = {shift_q[nvmem_pkg::ADDR_W-9:0], addr_q[7:0]};
                            end else if (idx_q == nvmem_pkg::IDX_LO) begin
                                addr_d = {addr_q[nvmem_pkg::ADDR_W-1:8], shift_q};
                            end else begin
                                // protected data is still acknowledged, address still moves
                                we_c = !wp_v;
                                addr_d = addr_q + nvmem_pkg::ADDR_STEP;
                            end
                        end
                    end
                end
                nvmem_pkg::ST_ACK: begin
                    if (scl_fall) begin
                        oe_d = 1'b0;
                        bit_cnt_d = nvmem_pkg::CNT_ZERO;
                        if (idx_q != nvmem_pkg::IDX_DATA) begin
                            idx_d = idx_q + nvmem_pkg::IDX_STEP;
                        end
                        if (idx_q == nvmem_pkg::IDX_DEV && rd_dir_q) begin
                            state_d = nvmem_pkg::ST_TX;
                            shift_d = rdata;
                            oe_d = !rdata[nvmem_pkg::BYTE_W-1];
                        end else begin
                            state_d = nvmem_pkg::ST_RX;
                        end
                    end
                end
                nvmem_pkg::ST_TX: begin
                    if (scl_fall) begin
                        if (bit_cnt_q == nvmem_pkg::BIT_LAST) begin
                            oe_d = 1'b0;
                            ackd_d = 1'b0;
                            state_d = nvmem_pkg::ST_MACK;
                        end else begin
                            shift_d = {shift_q[nvmem_pkg::BYTE_W-2:0], 1'b0};
                            bit_cnt_d = bit_cnt_q + nvmem_pkg::CNT_STEP;
                            oe_d = !shift_q[nvmem_pkg::BYTE_W-2];
                        end
                    end
                end
                nvmem_pkg::ST_MACK: begin
                    if (scl_rise) begin
                        // the byte was sent either way, so the pointer moves on
                        addr_d = addr_q + nvmem_pkg::ADDR_STEP;
                        if (!sda_v) begin
                            ackd_d = 1'b1;
                        end else begin
                            state_d = nvmem_pkg::ST_IDLE;
                        end
                    end else if (scl_fall && ackd_q) begin
                        state_d = nvmem_pkg::ST_TX;
                        shift_d = rdata;
                        bit_cnt_d = nvmem_pkg::CNT_ZERO;
                        oe_d = !rdata[nvmem_pkg::BYTE_W-1];
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            state_q <= nvmem_pkg::ST_IDLE;
            bit_cnt_q <= nvmem_pkg::CNT_ZERO;
            shift_q <= nvmem_pkg::BYTE_ZERO;
            idx_q <= nvmem_pkg::IDX_DEV;
            rd_dir_q <= 1'b0;
            ackd_q <= 1'b0;
            addr_q <= nvmem_pkg::ADDR_RST;
            oe_q <= 1'b0;
            sda_out <= 1'b0;
        end else begin
            state_q <= state_d;
            bit_cnt_q <= bit_cnt_d;
            shift_q <= shift_d;
            idx_q <= idx_d;
            rd_dir_q <= rd_dir_d;
            ackd_q <= ackd_d;
            addr_q <= addr_d;
            oe_q <= oe_d;
            sda_out <= 1'b0;
        end
    end

    assign sda_oe_out = oe_q;
    assign mem_bus.we = we_c;
    assign mem_bus.addr = addr_q;
    assign mem_bus.wdata = shift_q;

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    a_line_never_high: assert property (sda_out == 1'b0)
        else $error("data line driven high");
    a_stop_to_idle: assert property (stop_det |=> state_q == nvmem_pkg::ST_IDLE && !oe_q)
        else $error("stop did not return to standby");
    a_start_restarts: assert property (start_det |=>
        state_q == nvmem_pkg::ST_RX && bit_cnt_q == nvmem_pkg::CNT_ZERO
        && idx_q == nvmem_pkg::IDX_DEV)
        else $error("start did not restart address reception");
    a_protect_blocks: assert property (wp_v |-> !mem_bus.we)
        else $error("write while protected");
    a_mismatch_idle: assert property (
        state_q == nvmem_pkg::ST_RX && idx_q == nvmem_pkg::IDX_DEV && scl_fall && !match_c
        && bit_cnt_q == nvmem_pkg::BITS_PER_BYTE && !start_det && !stop_det
        |=> state_q == nvmem_pkg::ST_IDLE && !oe_q)
        else $error("mismatched address acknowledged");
    a_nack_release: assert property (
        state_q == nvmem_pkg::ST_MACK && scl_rise && sda_v && !start_det && !stop_det
        |=> state_q == nvmem_pkg::ST_IDLE && !oe_q [*3])
        else $error("bus not released after not-acknowledge");
    a_drive_on_fall: assert property ($rose(oe_q) |-> $past(scl_fall))
        else $error("data line taken low outside a clock fall");
    a_ack_slot: assert property (
        state_q == nvmem_pkg::ST_RX && idx_q != nvmem_pkg::IDX_DEV && scl_fall
        && bit_cnt_q == nvmem_pkg::BITS_PER_BYTE && !start_det && !stop_det
        |=> oe_q && state_q == nvmem_pkg::ST_ACK)
        else $error("received byte not acknowledged");
    a_write_commit: assert property (
        mem_bus.we |=> addr_q == $past(addr_q) + nvmem_pkg::ADDR_STEP)
        else $error("address did not advance after write");
    a_release_mack: assert property (state_q == nvmem_pkg::ST_MACK |-> !oe_q)
        else $error("line held during master acknowledge");
    a_idle_released: assert property (state_q == nvmem_pkg::ST_IDLE |-> !oe_q)
        else $error("line held in standby");
    a_ack_held: assert property (state_q == nvmem_pkg::ST_ACK |-> oe_q)
        else $error("line not held through acknowledge");
    a_shift_on_rise: assert property (
        state_q == nvmem_pkg::ST_RX && !scl_rise |=> $stable(shift_q))
        else $error("data taken outside a clock rise");
    a_oe_on_edge: assert property (
        $changed(oe_q) |-> $past(scl_fall) || $past(start_det) || $past(stop_det))
        else $error("line moved while clock high");
    a_bit_bound: assert property (bit_cnt_q <= nvmem_pkg::BITS_PER_BYTE)
        else $error("bit counter beyond one byte");
    a_write_after_addr: assert property (
        mem_bus.we |-> state_q == nvmem_pkg::ST_RX && idx_q == nvmem_pkg::IDX_DATA)
        else $error("write before both address bytes");
    a_read_starts_tx: assert property (
        state_q == nvmem_pkg::ST_ACK && idx_q == nvmem_pkg::IDX_DEV && rd_dir_q && scl_fall
        |=> state_q == nvmem_pkg::ST_TX)
        else $error("read not started after address");
    a_match_ack: assert property (
        state_q == nvmem_pkg::ST_RX && idx_q == nvmem_pkg::IDX_DEV && match_c && scl_fall
        && bit_cnt_q == nvmem_pkg::BITS_PER_BYTE |=> state_q == nvmem_pkg::ST_ACK && oe_q)
        else $error("matching address not acknowledged");
endmodule

// [tb/bus_master_model.sv]
`timescale 1ns/10ps
// two-wire master: the bus clock stands high outside frames
module bus_master_model (
    // clock
    input wire logic clk_in,
    // two-wire bus
    input wire logic sda_in,
    output logic scl_out,
    output logic sda_oe_out
);
    initial begin
        scl_out = 1'b1;
        sda_oe_out = 1'b0;
    end
    task automatic wait_clk(input int n);
        repeat (n) @(negedge clk_in);
    endtask
    // one bus clock, data set mid low phase, 4 clk low and 4 clk high
    task automatic bit_io(input logic pull_low, output logic s);
        wait_clk(2);
        sda_oe_out = pull_low;
        wait_clk(2);
        scl_out = 1'b1;
        wait_clk(2);
        s = sda_in;
        wait_clk(2);
        scl_out = 1'b0;
    endtask
    // start and stop move data while the clock is high
    task automatic start_cond();
        wait_clk(2);
        sda_oe_out = 1'b0;
        wait_clk(2);
        scl_out = 1'b1;
        wait_clk(4);
        sda_oe_out = 1'b1;
        wait_clk(4);
        scl_out = 1'b0;
    endtask
    task automatic stop_cond();
        wait_clk(2);
        sda_oe_out = 1'b1;
        wait_clk(2);
        scl_out = 1'b1;
        wait_clk(4);
        sda_oe_out = 1'b0;
        wait_clk(4);
    endtask
    // msb first; a short count leaves the byte unfinished
    task automatic put_bits(input logic [7:0] d, input int n);
        logic s;
        for (int i = 7; i > 7 - n; i--) begin
            bit_io(~d[i], s);
        end
    endtask
    // release on the ninth clock, ack is a low wire
    task automatic put_byte(input logic [7:0] d, output logic ack);
        logic s;
        put_bits(d, 8);
        bit_io(1'b0, s);
        ack = ~s;
    endtask
    task automatic get_byte(input logic ack, output logic [7:0] d);
        logic s;
        for (int i = 0; i < 8; i++) begin
            bit_io(1'b0, s);
            d = {d[6:0], s};
        end
        bit_io(ack, s);
    endtask
endmodule

// [tb/tb_serial_nv_memory_bus_slave.sv]
`timescale 1ns/10ps
module tb_serial_nv_memory_bus_slave;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic scl;
    logic m_oe;
    logic dev_sda;
    logic dev_oe;
    logic sda_wire;
    logic oe_prev = 1'b0;
    logic [2:0] strap = 3'h5;
    logic wp = 1'b0;
    logic ack;
    logic [7:0] rd;
    int fails = 0;
    int n_tests = 0;
    int cycles = 0;
    // pull-up on the data wire
    assign sda_wire = ~(dev_oe | m_oe);
    nvmem_bus_slave nvmem_bus_slave_i (.clk_in(clk_in), .rst_in(rst_in), .scl_in(scl),
        .sda_in(sda_wire), .sda_out(dev_sda), .sda_oe_out(dev_oe),
        .strap_addr_bit0(strap[0]), .strap_addr_bit1(strap[1]),
        .strap_addr_bit2(strap[2]), .wp_in(wp));
    bus_master_model bus_master_model_i (.clk_in(clk_in), .sda_in(sda_wire), .scl_out(scl),
        .sda_oe_out(m_oe));
    initial begin
        forever #20 clk_in = ~clk_in;
    end
    task automatic complete_run();
        if (fails == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
            fails++;
        end
    endtask
    // the device only pulls low, and only moves the wire while the clock is low
    always @(posedge clk_in) begin
        cycles++;
        if (!rst_in && (dev_sda !== 1'b0
            || (dev_oe !== oe_prev && scl === 1'b1))) begin
            $display("MISMATCH data drive expected 0 seen %b", dev_sda);
            fails++;
        end
        oe_prev <= dev_oe;
        if (cycles == 30000) begin
            fails++;
            complete_run();
        end
    end
    function automatic logic [7:0] dev_byte(input logic [2:0] s, input logic dir);
        return {nvmem_pkg::TYPE_CODE_DEF, s, dir};
    endfunction
    task automatic send(input logic [7:0] d, input logic exp);
        bus_master_model_i.put_byte(d, ack);
        check("ack", {7'h00, exp}, {7'h00, ack});
    endtask
    task automatic set_ptr(input logic [14:0] a);
        bus_master_model_i.start_cond();
        send(dev_byte(strap, 1'b0), 1'b1);
        send({1'b0, a[14:8]}, 1'b1);
        send(a[7:0], 1'b1);
    endtask
    task automatic read_at(input logic [14:0] a, input logic [7:0] exp);
        set_ptr(a);
        bus_master_model_i.start_cond();
        send(dev_byte(strap, 1'b1), 1'b1);
        bus_master_model_i.get_byte(1'b0, rd);
        check("read data", exp, rd);
        // give a device that ignored the not-acknowledge time to drive the next byte
        bus_master_model_i.wait_clk(4);
        check("release", 8'h00, {7'h00, dev_oe});
        bus_master_model_i.stop_cond();
    endtask
    // page write across the top of the array, no wait after stop
    task automatic t_write();
        set_ptr(15'h7fff);
        send(8'h11, 1'b1);
        send(8'h22, 1'b1);
        bus_master_model_i.stop_cond();
        set_ptr(15'h0010);
        send(8'h5a, 1'b1);
        bus_master_model_i.stop_cond();
    endtask
    task automatic t_seq_read();
        set_ptr(15'h7fff);
        bus_master_model_i.start_cond();
        send(dev_byte(strap, 1'b1), 1'b1);
        bus_master_model_i.get_byte(1'b1, rd);
        check("seq byte 0", 8'h11, rd);
        bus_master_model_i.get_byte(1'b0, rd);
        check("seq byte 1", 8'h22, rd);
        bus_master_model_i.wait_clk(4);
        check("release", 8'h00, {7'h00, dev_oe});
        bus_master_model_i.stop_cond();
    endtask
    task automatic t_match();
        for (int i = 0; i < 8; i++) begin
            bus_master_model_i.start_cond();
            send(dev_byte(i[2:0], 1'b0), i[2:0] == strap);
            bus_master_model_i.stop_cond();
        end
        bus_master_model_i.start_cond();
        send({~nvmem_pkg::TYPE_CODE_DEF, strap, 1'b0}, 1'b0);
        bus_master_model_i.stop_cond();
        strap = 3'h0;
        bus_master_model_i.start_cond();
        send(dev_byte(3'h0, 1'b0), 1'b1);
        bus_master_model_i.stop_cond();
        strap = 3'h5;
    endtask
    task automatic t_protect();
        wp = 1'b1;
        set_ptr(15'h7fff);
        send(8'h99, 1'b1);
        bus_master_model_i.stop_cond();
        read_at(15'h7fff, 8'h11);
        wp = 1'b0;
        read_at(15'h0000, 8'h22);
        set_ptr(15'h7fff);
        send(8'h99, 1'b1);
        bus_master_model_i.stop_cond();
        read_at(15'h7fff, 8'h99);
    endtask
    task automatic t_abort();
        set_ptr(15'h0010);
        bus_master_model_i.put_bits(8'h77, 4);
        bus_master_model_i.stop_cond();
        read_at(15'h0010, 8'h5a);
        set_ptr(15'h0010);
        bus_master_model_i.put_bits(8'h00, 5);
        bus_master_model_i.start_cond();
        send(dev_byte(strap, 1'b1), 1'b1);
        bus_master_model_i.get_byte(1'b0, rd);
        check("after restart", 8'h5a, rd);
        bus_master_model_i.stop_cond();
    endtask
    initial begin
        repeat (5) @(negedge clk_in);
        rst_in = 1'b0;
        repeat (3) @(negedge clk_in);
        t_write();
        t_seq_read();
        t_match();
        t_protect();
        t_abort();
        complete_run();
    end
endmodule
